/* File: hdl/wfc_pkg.sv */
// Shared constants of the watchdog fail-counter block
package wfc_pkg;
	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0] WFC_OFS_SAFETY_CFG = 8'h00;
	localparam logic [7:0] WFC_OFS_CHECK_CTRL = 8'h04;
	localparam logic [7:0] WFC_OFS_STATUS = 8'h08;
	localparam logic [7:0] WFC_OFS_FAIL_CNT = 8'h0c;
	localparam logic [7:0] WFC_OFS_WIN_CFG = 8'h10;
	localparam logic [7:0] WFC_OFS_ANSWER = 8'h14;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int WFC_BIT_RST_EN = 3;
	localparam int WFC_BIT_MODE = 5;
	localparam int WFC_BIT_DRV = 0;
	localparam int WFC_BIT_EARLY = 0;
	localparam int WFC_BIT_TIMEOUT = 1;
	localparam int WFC_BIT_ANS_GOOD = 0;
	localparam int WFC_POS_STATE = 4;
	localparam int WFC_POS_MODE_RD = 8;
	localparam int WFC_POS_RANGE = 9;
	localparam int WFC_POS_WIN2 = 8;

	// ****************************************************************
	// Reset and load values
	// ****************************************************************
	localparam logic [7:0] WFC_SAFETY_CFG_RST = 8'h00;
	localparam logic [2:0] WFC_FAIL_LOAD = 3'h5;
	localparam logic [2:0] WFC_FAIL_MAX = 3'h7;
	localparam logic [2:0] WFC_FAIL_MIN = 3'h0;
	localparam logic [6:0] WFC_WIN1_RST = 7'h10;
	localparam logic [4:0] WFC_WIN2_RST = 5'h08;
	localparam logic [1:0] WFC_RESP_OKAY = 2'h0;
	localparam logic [1:0] WFC_RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int WFC_CLK_MHZ = 125;
	localparam int WFC_QUAL_US = 32;
	localparam int WFC_QUAL_CYC = WFC_QUAL_US * WFC_CLK_MHZ;
	localparam int WFC_STEP_NS = 550000;
	localparam int WFC_STEP_CYC = WFC_STEP_NS * WFC_CLK_MHZ / 1000;
	localparam int WFC_RST_HOLD_CYC = 16;

	typedef enum logic [1:0] {
		WFC_ST_RESET = 2'b00,
		WFC_ST_DIAG = 2'b01,
		WFC_ST_ACTIVE = 2'b10
	} wfc_dev_state_t;

	// Saturating step of the fail counter
	function automatic logic [2:0] wfc_step(input logic [2:0] cnt, input logic up);
		logic [2:0] r;
		r = cnt;
		if (up && cnt != WFC_FAIL_MAX) begin
			r = cnt + 3'h1;
		end else if (!up && cnt != WFC_FAIL_MIN) begin
			r = cnt - 3'h1;
		end
		return r;
	endfunction
endpackage

/* File: hdl/wfc_trig_qual.sv */
// Pulse qualifier for watchdog triggers on the shared error/trigger pin
`timescale 1ns/1ps
module wfc_trig_qual
	import wfc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic enable,
	input wire logic error_trigger_in,
	output logic trig_pulse
);
	logic pin_q, pin_d;
	logic [12:0] hcnt_q, hcnt_d;
	logic pulse_q, pulse_d;

	assign trig_pulse = pulse_q;

	// A high phase longer than the qualification time, closed by a falling edge
	always_comb begin
		pin_d = error_trigger_in;
		pulse_d = 1'b0;
		hcnt_d = hcnt_q;
		if (!pin_q && error_trigger_in) begin
			hcnt_d = 13'h0;
		end else if (pin_q && error_trigger_in && hcnt_q <= 13'(WFC_QUAL_CYC)) begin
			hcnt_d = hcnt_q + 13'h1;
		end
		if (pin_q && !error_trigger_in && hcnt_q > 13'(WFC_QUAL_CYC)) begin
			pulse_d = enable; // [RULE19]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q <= 1'b0;
			hcnt_q <= 13'h0;
			pulse_q <= 1'b0;
		end else if (ce) begin
			pin_q <= pin_d;
			hcnt_q <= hcnt_d;
			pulse_q <= pulse_d;
		end
	end
endmodule

/* File: hdl/wfc_win_timer.sv */
// Watchdog sequence timer: closed window, then open window, then time-out
`timescale 1ns/1ps
module wfc_win_timer
	import wfc_pkg::*;
#(
	parameter int unsigned STEP_CYC = WFC_STEP_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic run,
	input wire logic restart,
	input wire logic [6:0] win1_len,
	input wire logic [4:0] win2_len,
	output logic open_win,
	output logic timeout
);
	logic [16:0] pre_q, pre_d;
	logic [6:0] wcnt_q, wcnt_d;
	logic open_q, open_d;
	logic to_q, to_d;
	logic step;

	assign open_win = open_q;
	assign timeout = to_q;
	assign step = (pre_q == 17'(STEP_CYC - 1));

	always_comb begin
		pre_d = step ? 17'h0 : pre_q + 17'h1;
		wcnt_d = wcnt_q;
		open_d = open_q;
		to_d = 1'b0;
		if (!run || restart) begin
			pre_d = 17'h0;
			wcnt_d = 7'h0;
			open_d = 1'b0;
		end else if (step) begin
			wcnt_d = wcnt_q + 7'h1;
			// Closed window of win1_len steps (at least one), open of win2_len+1
			if (!open_q && wcnt_d >= win1_len) begin
				open_d = 1'b1;
				wcnt_d = 7'h0;
			end else if (open_q && wcnt_d > {2'h0, win2_len}) begin
				open_d = 1'b0;
				wcnt_d = 7'h0;
				to_d = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q <= 17'h0;
			wcnt_q <= 7'h0;
			open_q <= 1'b0;
			to_q <= 1'b0;
		end else if (ce) begin
			pre_q <= pre_d;
			wcnt_q <= wcnt_d;
			open_q <= open_d;
			to_q <= to_d;
		end
	end
endmodule

/* File: hdl/wfc_top.sv */
// Watchdog fail counter, drive-enable gating and MCU reset with AXI4-Lite registers
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Incorrect MCU operation forces drive_enable_out low.
// RULE2: While watchdog is in range, drive_enable_out follows the software drive bit.
// RULE3: Every reset-to-diagnostic entry returns the watchdog to pulse-trigger mode.
// RULE4: In trigger mode the MCU pulses the error/trigger pin per event.
// RULE5: In question-answer mode the MCU answers by register writes, not pulses.
// RULE6: Mode bit 5 is accepted only in the diagnostic state.
// RULE7: MCU should avoid the error-signal monitor while in trigger mode.
// RULE8: Three-bit fail count of five or more is out of range; drive held low.
// RULE9: Count four or less is in range; drive high if bit set, no error.
// RULE10: Fail counter updates whatever the reset-enable bit 3 holds.
// RULE11: Good event decrements the counter, stopping at zero.
// RULE12: Bad event increments the counter, stopping at seven.
// RULE13: Time-out increments the counter, stopping at seven, and sets status bit 1.
// RULE14: Counter loads five entering diagnostic and on diagnostic-to-active.
// RULE15: A bad event at seven leaves the counter at seven.
// RULE16: Reset enabled and counter seven: next bad or time-out enters reset state.
// RULE17: In the reset state the counter is reloaded with five.
// RULE18: Setting reset-enable while counter is seven enters reset at once.
// RULE19: Trigger is a high pulse longer than 32 us, ended by a falling edge.
// RULE20: Trigger in closed window is bad, sets early flag, restarts sequence.
// RULE21: Trigger in open window is good and restarts the sequence.
// RULE22: Simultaneous events apply one by one in fixed order with saturation.
module wfc_top
	import wfc_pkg::*;
#(
	parameter int unsigned STEP_CYC = WFC_STEP_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic error_trigger_in,
	input wire logic other_error,
	input wire logic go_active,
	output logic drive_enable_out,
	output logic mcu_reset_n_out
);
	// ****************************************************************
	// State
	// ****************************************************************
	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [7:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] safety_function_config_reg_q, safety_function_config_reg_d;
	logic drive_enable_ctrl_bit_q, drive_enable_ctrl_bit_d;
	logic early_q, early_d, timeout_flag_q, timeout_flag_d;
	logic [2:0] wdog_fail_count_q, wdog_fail_count_d;
	wfc_dev_state_t state_q, state_d;
	logic [4:0] rst_cnt_q, rst_cnt_d;
	logic [6:0] win1_q, win1_d;
	logic [4:0] win2_q, win2_d;
	logic drv_q, drv_d, mcu_reset_n_out_q, mcu_reset_n_out_d;
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

	logic do_write, ans_wr, ans_good, qual_pulse, open_win, to_evt;
	logic trig_evt, good_evt, bad_evt, in_range, running, qa_mode, rst_en;
	logic rst_en_rise, enter_diag, seq_restart;
	logic [2:0] cnt_tmp;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign drive_enable_out = drv_q;
	assign mcu_reset_n_out = mcu_reset_n_out_q;

	// ****************************************************************
	// Event sources
	// ****************************************************************
	assign running = (state_q != WFC_ST_RESET);
	assign qa_mode = safety_function_config_reg_q[WFC_BIT_MODE];
	assign rst_en = safety_function_config_reg_q[WFC_BIT_RST_EN];
	assign do_write = aw_got_q && w_got_q && !bvalid_q;
	assign ans_wr = do_write && waddr_q == WFC_OFS_ANSWER && wstrb_q[0];
	assign ans_good = wdata_q[WFC_BIT_ANS_GOOD];
	// Pin triggers count only in trigger mode, answers only in Q&A mode
	assign trig_evt = running && (qa_mode ? ans_wr : qual_pulse); // [RULE4] [RULE5]
	// A negative answer is bad whatever the window
	assign good_evt = trig_evt && open_win && (!qa_mode || ans_good); // [RULE21]
	assign bad_evt = trig_evt && !good_evt; // [RULE20]
	assign in_range = (wdog_fail_count_q < WFC_FAIL_LOAD); // [RULE8] [RULE9]
	assign enter_diag = (state_q == WFC_ST_RESET) && (rst_cnt_q == 5'(WFC_RST_HOLD_CYC - 1));
	assign seq_restart = trig_evt || enter_diag; // [RULE20] [RULE21]
	assign rst_en_rise = do_write && waddr_q == WFC_OFS_SAFETY_CFG && wstrb_q[0]
		&& wdata_q[WFC_BIT_RST_EN] && !rst_en;

	wfc_trig_qual u_qual (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.enable(running && !qa_mode),
		.error_trigger_in(error_trigger_in),
		.trig_pulse(qual_pulse)
	);

	wfc_win_timer #(
		.STEP_CYC(STEP_CYC)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.run(running),
		.restart(seq_restart),
		.win1_len(win1_q),
		.win2_len(win2_q),
		.open_win(open_win),
		.timeout(to_evt)
	);

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	always_comb begin
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_d = 1'b1;
			waddr_d = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (waddr_q <= WFC_OFS_ANSWER) ? WFC_RESP_OKAY : WFC_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_d = 1'b1;
			rresp_d = WFC_RESP_OKAY;
			rdata_d = 32'h0;
			case ({s_axi_araddr[7:2], 2'b00})
				WFC_OFS_SAFETY_CFG: rdata_d[7:0] = safety_function_config_reg_q;
				WFC_OFS_CHECK_CTRL: rdata_d[WFC_BIT_DRV] = drive_enable_ctrl_bit_q;
				WFC_OFS_STATUS: begin
					rdata_d[WFC_BIT_EARLY] = early_q;
					rdata_d[WFC_BIT_TIMEOUT] = timeout_flag_q;
				end
				WFC_OFS_FAIL_CNT: begin
					rdata_d[2:0] = wdog_fail_count_q;
					rdata_d[WFC_POS_STATE +: 2] = state_q;
					rdata_d[WFC_POS_MODE_RD] = qa_mode;
					rdata_d[WFC_POS_RANGE] = in_range;
				end
				WFC_OFS_WIN_CFG: begin
					rdata_d[6:0] = win1_q;
					rdata_d[WFC_POS_WIN2 +: 5] = win2_q;
				end
				WFC_OFS_ANSWER: rdata_d = 32'h0;
				default: rresp_d = WFC_RESP_SLVERR;
			endcase
		end
		// Ready flags registered from next values, so they equal the held-state terms
		awready_d = !aw_got_d && !bvalid_d;
		wready_d = !w_got_d && !bvalid_d;
		arready_d = !rvalid_d;
	end

	// ****************************************************************
	// Configuration, status and watchdog core
	// ****************************************************************
	always_comb begin
		safety_function_config_reg_d = safety_function_config_reg_q;
		drive_enable_ctrl_bit_d = drive_enable_ctrl_bit_q;
		win1_d = win1_q;
		win2_d = win2_q;
		early_d = early_q;
		timeout_flag_d = timeout_flag_q;
		state_d = state_q;
		rst_cnt_d = rst_cnt_q;
		wdog_fail_count_d = wdog_fail_count_q;
		cnt_tmp = wdog_fail_count_q;
		if (do_write && wstrb_q[0]) begin
			case (waddr_q)
				WFC_OFS_SAFETY_CFG: begin
					safety_function_config_reg_d = wdata_q[7:0];
					// Mode is locked outside the diagnostic state
					if (state_q != WFC_ST_DIAG) begin
						safety_function_config_reg_d[WFC_BIT_MODE] = qa_mode; // [RULE6]
					end
				end
				WFC_OFS_CHECK_CTRL: drive_enable_ctrl_bit_d = wdata_q[WFC_BIT_DRV];
				// Write one to clear; a new event below still wins
				WFC_OFS_STATUS: begin
					early_d = early_q && !wdata_q[WFC_BIT_EARLY];
					timeout_flag_d = timeout_flag_q && !wdata_q[WFC_BIT_TIMEOUT];
				end
				WFC_OFS_WIN_CFG: begin
					if (state_q == WFC_ST_DIAG) begin
						win1_d = wdata_q[6:0];
						win2_d = wdata_q[WFC_POS_WIN2 +: 5];
					end
				end
				default: begin
				end
			endcase
		end
		if (bad_evt) begin
			early_d = early_d || open_win == 1'b0; // [RULE20]
		end
		if (to_evt && running) begin
			timeout_flag_d = 1'b1; // [RULE13]
		end
		// Fixed order: good, then bad, then time-out, each saturating
		if (good_evt) begin
			cnt_tmp = wfc_step(cnt_tmp, 1'b0); // [RULE11] [RULE22]
		end
		if (bad_evt) begin
			cnt_tmp = wfc_step(cnt_tmp, 1'b1); // [RULE12] [RULE15] [RULE22]
		end
		if (to_evt) begin
			cnt_tmp = wfc_step(cnt_tmp, 1'b1); // [RULE13] [RULE22]
		end
		case (state_q)
			WFC_ST_RESET: begin
				wdog_fail_count_d = WFC_FAIL_LOAD; // [RULE17]
				rst_cnt_d = rst_cnt_q + 5'h1;
				if (enter_diag) begin
					state_d = WFC_ST_DIAG;
					rst_cnt_d = 5'h0;
					safety_function_config_reg_d[WFC_BIT_MODE] = 1'b0; // [RULE3]
					wdog_fail_count_d = WFC_FAIL_LOAD; // [RULE14]
				end
			end
			WFC_ST_DIAG, WFC_ST_ACTIVE: begin
				wdog_fail_count_d = cnt_tmp; // [RULE10]
				if (state_q == WFC_ST_DIAG && go_active) begin
					state_d = WFC_ST_ACTIVE;
					wdog_fail_count_d = WFC_FAIL_LOAD; // [RULE14]
				end
				if (wdog_fail_count_q == WFC_FAIL_MAX && rst_en && (bad_evt || to_evt)) begin
					state_d = WFC_ST_RESET; // [RULE16]
					rst_cnt_d = 5'h0;
				end
				if (wdog_fail_count_q == WFC_FAIL_MAX && rst_en_rise) begin
					state_d = WFC_ST_RESET; // [RULE18]
					rst_cnt_d = 5'h0;
				end
			end
			default: begin
				state_d = WFC_ST_RESET;
				rst_cnt_d = 5'h0;
			end
		endcase
	end

	// ****************************************************************
	// Pin outputs
	// ****************************************************************
	always_comb begin
		mcu_reset_n_out_d = (state_d != WFC_ST_RESET); // [RULE16]
		// Registered from next-state values so pins move with the counter
		drv_d = (state_d != WFC_ST_RESET) && (wdog_fail_count_d < WFC_FAIL_LOAD)
			&& drive_enable_ctrl_bit_d && !other_error; // [RULE1] [RULE2] [RULE8] [RULE9]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= WFC_RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= WFC_RESP_OKAY;
			rdata_q <= 32'h0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
			safety_function_config_reg_q <= WFC_SAFETY_CFG_RST;
			drive_enable_ctrl_bit_q <= 1'b0;
			win1_q <= WFC_WIN1_RST;
			win2_q <= WFC_WIN2_RST;
			early_q <= 1'b0;
			timeout_flag_q <= 1'b0;
			state_q <= WFC_ST_RESET;
			rst_cnt_q <= 5'h0;
			wdog_fail_count_q <= WFC_FAIL_LOAD;
			drv_q <= 1'b0;
			mcu_reset_n_out_q <= 1'b0;
		end else if (ce) begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
			safety_function_config_reg_q <= safety_function_config_reg_d;
			drive_enable_ctrl_bit_q <= drive_enable_ctrl_bit_d;
			win1_q <= win1_d;
			win2_q <= win2_d;
			early_q <= early_d;
			timeout_flag_q <= timeout_flag_d;
			state_q <= state_d;
			rst_cnt_q <= rst_cnt_d;
			wdog_fail_count_q <= wdog_fail_count_d;
			drv_q <= drv_d;
			mcu_reset_n_out_q <= mcu_reset_n_out_d;
		end
	end
endmodule

/* File: bench/wfc_top_asserts.sv */
// Port checker of the watchdog fail-counter block
`timescale 1ns/1ps
module wfc_top_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic other_error,
	input wire logic drive_enable_out,
	input wire logic mcu_reset_n_out
);
	logic [7:0] low_q;
	logic [7:0] low_d;

	// Cycles the MCU has been held in reset, so the hold time can be checked
	always_comb begin
		low_d = mcu_reset_n_out ? 8'h00 : low_q + {7'h0, ce};
	end
	always_ff @(posedge aclk) begin
		low_q <= aresetn ? low_d : 8'h00;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_drive_other: assert property (ce && other_error |=> !drive_enable_out)
		else $error("drive enable high under another error");
	a_drive_in_reset: assert property (!mcu_reset_n_out |=> !drive_enable_out)
		else $error("drive enable high in reset state");
	a_drive_cause: assert property ($rose(drive_enable_out) |-> !$past(other_error) && mcu_reset_n_out)
		else $error("drive enable rose without cause");
	a_entry_low: assert property ($rose(mcu_reset_n_out) |-> !drive_enable_out [*3])
		else $error("drive enable high on diagnostic entry");
	a_reset_len: assert property ($rose(mcu_reset_n_out) |-> low_q >= 8'd15 && low_q <= 8'd17)
		else $error("reset hold length wrong");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_lat: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule

/* File: bench/wfc_mcu_model.sv */
// Behavioural safety MCU sending watchdog trigger pulses
`timescale 1ns/1ps
module wfc_mcu_model (
	input wire logic aclk,
	input wire logic fire,
	input wire logic [15:0] hi_len,
	output logic error_trigger_in,
	output logic busy
);
	// Pin idles low; the error signal monitor is never used by this MCU
	// One event is one high pulse, its length chosen by the caller
	initial begin
		error_trigger_in = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge aclk);
			if (fire && !busy) begin
				busy <= 1'b1;
				error_trigger_in <= 1'b1;
				repeat (hi_len) @(posedge aclk);
				error_trigger_in <= 1'b0;
				busy <= 1'b0;
			end
		end
	end
endmodule

/* File: bench/wfc_top_tb_top.sv */
// Self-checking bench of the watchdog fail-counter block
`timescale 1ns/1ps
module wfc_top_tb_top
	import wfc_pkg::*;
;
	typedef struct {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e; logic [1:0] r;} wfc_row_t;
	// Window 1 of 100 steps of 50 cycles, window 2 of 32 steps
	localparam int GAP = 5100;
	logic aclk, aresetn, ce, go_active, other_error, fire, busy, trig;
	logic [15:0] hi_len;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic drive_enable_out, mcu_reset_n_out;
	int err_count, n_checks;
	wfc_row_t rows [6] = '{
		'{WFC_OFS_FAIL_CNT, 1'b0, 32'h0, 32'h15, WFC_RESP_OKAY},
		'{WFC_OFS_WIN_CFG, 1'b1, 32'h1f64, 32'h1f64, WFC_RESP_OKAY},
		'{WFC_OFS_CHECK_CTRL, 1'b1, 32'h1, 32'h1, WFC_RESP_OKAY},
		'{WFC_OFS_SAFETY_CFG, 1'b1, 32'h5, 32'h5, WFC_RESP_OKAY},
		'{WFC_OFS_ANSWER, 1'b0, 32'h0, 32'h0, WFC_RESP_OKAY},
		'{8'h18, 1'b1, 32'hff, 32'h0, WFC_RESP_SLVERR}};

	wfc_top #(.STEP_CYC(50)) DUT (.aclk, .aresetn, .ce, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.error_trigger_in(trig), .other_error, .go_active, .drive_enable_out, .mcu_reset_n_out);
	wfc_mcu_model MCU (.aclk, .fire, .hi_len, .error_trigger_in(trig), .busy);

	// ****************************************************************
	// Bus and check tasks
	// ****************************************************************
	task report_and_stop();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// Response ready is raised late on purpose so the slave must hold its answer
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		repeat (2) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		axi_wr(a, d, resp);
		chk("bresp", {32'h0, er}, {32'h0, resp});
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		axi_rd(a, rd, resp);
		chk(nm, {er, e}, {resp, rd});
	endtask
	// Answers travel as register writes, never as pin pulses
	task ans(input logic b);
		axi_wr(WFC_OFS_ANSWER, {31'h0, b}, resp);
	endtask
	task pulse(input logic [15:0] len);
		int n;
		@(posedge aclk);
		hi_len <= len;
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		n = 0;
		do @(posedge aclk); while (busy && ++n < 9000);
	endtask
	task wait_mcu_reset_n_out(input logic v);
		int n;
		n = 0;
		do @(posedge aclk); while (mcu_reset_n_out !== v && ++n < 200);
		chk("reset pin", 34'(v), 34'(mcu_reset_n_out));
	endtask
	function automatic logic [31:0] fv(logic [2:0] c, logic [1:0] s, logic m);
		return {22'h0, c <= 3'h4, m, 2'b00, s, 1'b0, c};
	endfunction

	// ****************************************************************
	// Clock, watchdog and test sequence
	// ****************************************************************
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	initial begin
		#600000;
		err_count++;
		report_and_stop();
	end
	initial begin
		{aresetn, go_active, other_error, fire, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{hi_len, s_axi_wdata, err_count, n_checks} = '0;
		ce = 1'b1;
		repeat (8) @(posedge aclk);
		chk("drive in reset", 34'h0, 34'(drive_enable_out));
		aresetn <= 1'b1;
		wait_mcu_reset_n_out(1'b1);
		for (int i = 0; i < 6; i++) begin
			if (rows[i].wr) wrc(rows[i].a, rows[i].d, rows[i].r);
			rdc("row", rows[i].a, rows[i].e, rows[i].r);
		end
		pulse(4100);
		rdc("first bad", WFC_OFS_FAIL_CNT, fv(3'h6, 2'h1, 1'b0), 2'h0);
		wrc(WFC_OFS_STATUS, 32'h3, WFC_RESP_OKAY);
		pulse(4100);
		rdc("bad", WFC_OFS_FAIL_CNT, fv(3'h7, 2'h1, 1'b0), 2'h0);
		rdc("early", WFC_OFS_STATUS, 32'h1, WFC_RESP_OKAY);
		pulse(5200);
		rdc("good", WFC_OFS_FAIL_CNT, fv(3'h6, 2'h1, 1'b0), 2'h0);
		pulse(3000);
		rdc("short", WFC_OFS_FAIL_CNT, fv(3'h6, 2'h1, 1'b0), 2'h0);
		wrc(WFC_OFS_SAFETY_CFG, 32'h20, WFC_RESP_OKAY);
		repeat (4) ans(1'b1);
		rdc("saturate", WFC_OFS_FAIL_CNT, fv(3'h7, 2'h1, 1'b1), 2'h0);
		for (int i = 0; i < 3; i++) begin
			repeat (GAP) @(posedge aclk);
			ans(1'b1);
		end
		rdc("goods", WFC_OFS_FAIL_CNT, fv(3'h4, 2'h1, 1'b1), 2'h0);
		chk("drive on", 34'h1, 34'(drive_enable_out));
		other_error <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("drive other", 34'h0, 34'(drive_enable_out));
		other_error <= 1'b0;
		wrc(WFC_OFS_CHECK_CTRL, 32'h0, WFC_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("drive ctrl off", 34'h0, 34'(drive_enable_out));
		wrc(WFC_OFS_CHECK_CTRL, 32'h1, WFC_RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk("drive ctrl on", 34'h1, 34'(drive_enable_out));
		repeat (GAP) @(posedge aclk);
		ans(1'b0);
		rdc("negative", WFC_OFS_FAIL_CNT, fv(3'h5, 2'h1, 1'b1), 2'h0);
		chk("drive out of range", 34'h0, 34'(drive_enable_out));
		wrc(WFC_OFS_STATUS, 32'h3, WFC_RESP_OKAY);
		repeat (6700) @(posedge aclk);
		rdc("timeout flag", WFC_OFS_STATUS, 32'h2, WFC_RESP_OKAY);
		rdc("timeout", WFC_OFS_FAIL_CNT, fv(3'h6, 2'h1, 1'b1), 2'h0);
		go_active <= 1'b1;
		@(posedge aclk);
		go_active <= 1'b0;
		rdc("active", WFC_OFS_FAIL_CNT, fv(3'h5, 2'h2, 1'b1), 2'h0);
		wrc(WFC_OFS_SAFETY_CFG, 32'h0, WFC_RESP_OKAY);
		rdc("mode lock", WFC_OFS_FAIL_CNT, fv(3'h5, 2'h2, 1'b1), 2'h0);
		repeat (2) ans(1'b1);
		wrc(WFC_OFS_SAFETY_CFG, 32'h28, WFC_RESP_OKAY);
		wait_mcu_reset_n_out(1'b0);
		wait_mcu_reset_n_out(1'b1);
		rdc("reload", WFC_OFS_FAIL_CNT, fv(3'h5, 2'h1, 1'b0), 2'h0);
		wrc(WFC_OFS_SAFETY_CFG, 32'h28, WFC_RESP_OKAY);
		repeat (2) ans(1'b1);
		chk("held at seven", 34'h1, 34'(mcu_reset_n_out));
		ans(1'b1);
		wait_mcu_reset_n_out(1'b0);
		// With the clock enable low the reset hold must not run out
		ce <= 1'b0;
		repeat (40) @(posedge aclk);
		chk("frozen reset", 34'h0, 34'(mcu_reset_n_out));
		report_and_stop();
	end
endmodule

bind wfc_top wfc_top_chk CHK (.aclk, .aresetn, .ce, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .other_error, .drive_enable_out,
	.mcu_reset_n_out);
